//--- pkg/on_chip_peripheral_bus_decode_pkg.sv
// Package: register offset, enable bit positions, address windows and route codes for the peripheral enable decode.
package on_chip_peripheral_bus_decode_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register.
    localparam logic [15:0] PERIPH_ENABLES_OFFSET = 16'hF024;
    localparam logic [11:0] PERIPH_ENABLES_RESET = 12'h005;
    localparam int ENABLE_BITS = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Bit positions.
    localparam int FIRST_CAN_BIT = 0;
    localparam int SECOND_CAN_BIT = 1;
    localparam int SMALL_RAM_BIT = 2;
    localparam int LARGE_RAM_BIT = 3;
    localparam int RTC_BIT = 4;
    localparam int FLASH_BIT = 5;
    localparam int PWM_BIT = 6;
    localparam int ASYNC_BIT = 7;
    localparam int SYNC_BIT = 8;
    localparam int TWO_WIRE_BIT = 9;
    localparam int MISC_BIT = 10;
    localparam int PORT_BIT = 11;

    ////////////////////////////////////////////////////////////////////////////
    // Address windows (24-bit byte addresses, inclusive).
    localparam logic [23:0] SYNC_LO = 24'h00E800;
    localparam logic [23:0] SYNC_HI = 24'h00E8FF;
    localparam logic [23:0] ASYNC_LO = 24'h00E900;
    localparam logic [23:0] ASYNC_HI = 24'h00E9FF;
    localparam logic [23:0] TWO_WIRE_LO = 24'h00EA00;
    localparam logic [23:0] TWO_WIRE_HI = 24'h00EAFF;
    localparam logic [23:0] MISC_LO = 24'h00EB00;
    localparam logic [23:0] MISC_HI = 24'h00EB7F;
    localparam logic [23:0] PORT_LO = 24'h00EB80;
    localparam logic [23:0] PORT_HI = 24'h00EBFF;
    localparam logic [23:0] PWM_LO = 24'h00EC00;
    localparam logic [23:0] PWM_HI = 24'h00ECFF;
    localparam logic [23:0] RTC_LO = 24'h00ED00;
    localparam logic [23:0] RTC_HI = 24'h00EDFF;
    localparam logic [23:0] CAN_LO = 24'h00EC00;
    localparam logic [23:0] CAN_HI = 24'h00EFFF;
    localparam logic [23:0] SMALL_RAM_LO = 24'h00E000;
    localparam logic [23:0] SMALL_RAM_HI = 24'h00E7FF;
    localparam logic [23:0] FLASH_LO = 24'h090000;
    localparam logic [23:0] FLASH_HI = 24'h0EFFFF;
    localparam logic [23:0] LARGE_RAM_LO = 24'h0F0000;
    localparam logic [23:0] LARGE_RAM_HI = 24'h0FFFFF;

    ////////////////////////////////////////////////////////////////////////////
    // Route targets.
    typedef enum logic [1:0] {
        ROUTE_INTERNAL,
        ROUTE_ON_CHIP,
        ROUTE_EXTERNAL,
        ROUTE_NONE
    } route_t;

endpackage

//--- logic/window_match.sv
// Holds the inclusive address window comparator used for every routing window.
`timescale 1ns/100ps
module window_match #(
    parameter logic [23:0] LO = 24'h000000,
    parameter logic [23:0] HI = 24'h000000
) (
    // Address.
    input wire logic [23:0] addr,
    // Result.
    output logic hit
);
    assign hit = (addr >= LO) && (addr <= HI);
endmodule

//--- logic/on_chip_peripheral_bus_peripheral_enable_decode.sv
// Holds the peripheral enable register and the access routing decode of the on-chip peripheral bus.
// Functional notes
// - Extra ports off: external only if all off
// - Misc/timer off: external only if all off
// - Two-wire off: external only if all off
// - Sync serial off: external only if all off
// - Async serial off: printed list, sync omitted; the code waits for the whole group to be off, sync included
// - Second PWM off: external only if all off
// - Flash off: external only if large RAM off
// - Clock module off: external only if all off
// - Large RAM off: external only if flash off
// - Second CAN off: pins freed, conditional external
// - First CAN off: pins freed, conditional external
// - Reset enables first CAN and small RAM
// - Writes ignored after global bus enable set
`timescale 1ns/100ps
module on_chip_peripheral_bus_peripheral_enable_decode (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Register port of the special function register space.
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic regHit,
    // Global enable from the system configuration register.
    input wire logic globalExtBusEnable,
    // CPU access request.
    input wire logic accessStart,
    input wire logic [23:0] accessAddr,
    // Routing result for the access in flight.
    output logic [1:0] accessRoute,
    output logic [11:0] onChipSelect,
    // Enable levels to the peripherals.
    output logic [11:0] peripheralEnables,
    output logic firstCanPinsOwned,
    output logic secondCanPinsOwned
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic [11:0] enables;
        logic [15:0] rdata;
        logic [1:0] route;
        logic [11:0] select;
    } state_t;

    state_t state_reg;
    state_t state_next;

    localparam int NW = 10;
    // Comparator order: sync, async, two-wire, misc, ports, PWM, clock, CAN, small RAM, flash.
    localparam logic [23:0] LOS [NW] = '{
        on_chip_peripheral_bus_decode_pkg::SYNC_LO,
        on_chip_peripheral_bus_decode_pkg::ASYNC_LO,
        on_chip_peripheral_bus_decode_pkg::TWO_WIRE_LO,
        on_chip_peripheral_bus_decode_pkg::MISC_LO,
        on_chip_peripheral_bus_decode_pkg::PORT_LO,
        on_chip_peripheral_bus_decode_pkg::PWM_LO,
        on_chip_peripheral_bus_decode_pkg::RTC_LO,
        on_chip_peripheral_bus_decode_pkg::CAN_LO,
        on_chip_peripheral_bus_decode_pkg::SMALL_RAM_LO,
        on_chip_peripheral_bus_decode_pkg::FLASH_LO
    };
    localparam logic [23:0] HIS [NW] = '{
        on_chip_peripheral_bus_decode_pkg::SYNC_HI,
        on_chip_peripheral_bus_decode_pkg::ASYNC_HI,
        on_chip_peripheral_bus_decode_pkg::TWO_WIRE_HI,
        on_chip_peripheral_bus_decode_pkg::MISC_HI,
        on_chip_peripheral_bus_decode_pkg::PORT_HI,
        on_chip_peripheral_bus_decode_pkg::PWM_HI,
        on_chip_peripheral_bus_decode_pkg::RTC_HI,
        on_chip_peripheral_bus_decode_pkg::CAN_HI,
        on_chip_peripheral_bus_decode_pkg::SMALL_RAM_HI,
        on_chip_peripheral_bus_decode_pkg::FLASH_HI
    };

    logic [NW-1:0] hits;
    logic largeRamHit;

    genvar gi;
    generate
        for (gi = 0; gi < NW; gi++) begin : g_win
            window_match #(.LO(LOS[gi]), .HI(HIS[gi])) u_win (
                .addr(accessAddr),
                .hit(hits[gi])
            );
        end
    endgenerate

    window_match #(.LO(on_chip_peripheral_bus_decode_pkg::LARGE_RAM_LO), .HI(on_chip_peripheral_bus_decode_pkg::LARGE_RAM_HI)) u_large (
        .addr(accessAddr),
        .hit(largeRamHit)
    );

    // True when every enable bit in mask is clear.
    function automatic logic allClear(input logic [11:0] en, input logic [11:0] mask);
        allClear = ((en & mask) == 12'h000);
    endfunction

    // Builds a mask with the two given enable bits set.
    function automatic logic [11:0] bitsOf(input int a, input int b);
        bitsOf = 12'h000;
        bitsOf[a] = 1'b1;
        bitsOf[b] = 1'b1;
    endfunction

    // Peripheral window group: both CAN, clock, async, sync, two-wire, PWM, misc, ports.
    localparam logic [11:0] PERIPH_MASK = 12'hFD3;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        logic [11:0] en;
        logic [11:0] sel;
        logic ext;
        logic hitAny;
        en = 12'h000;
        sel = 12'h000;
        ext = 1'b0;
        hitAny = 1'b0;
        state_next = state_reg;
        state_next.rdata = 16'h0000;
        if (regSel && regWrite && regHit && !globalExtBusEnable) begin
            // Reserved bits are dropped; software must write them as zero anyway.
            state_next.enables = regWdata[11:0];
        end
        if (regSel && !regWrite && regHit) begin
            state_next.rdata = {4'h0, state_reg.enables};
        end
        if (accessStart) begin
            // The enables held before this edge steer the decode; a same-cycle write only affects later accesses.
            en = state_reg.enables;
            // Enabled modules own their windows. The CAN window overlaps the PWM and clock windows,
            // so those two win inside their own ranges while they are enabled.
            if (hits[0] && en[on_chip_peripheral_bus_decode_pkg::SYNC_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::SYNC_BIT] = 1'b1;
            end
            if (hits[1] && en[on_chip_peripheral_bus_decode_pkg::ASYNC_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::ASYNC_BIT] = 1'b1;
            end
            if (hits[2] && en[on_chip_peripheral_bus_decode_pkg::TWO_WIRE_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::TWO_WIRE_BIT] = 1'b1;
            end
            if (hits[3] && en[on_chip_peripheral_bus_decode_pkg::MISC_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::MISC_BIT] = 1'b1;
            end
            if (hits[4] && en[on_chip_peripheral_bus_decode_pkg::PORT_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::PORT_BIT] = 1'b1;
            end
            if (hits[5] && en[on_chip_peripheral_bus_decode_pkg::PWM_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::PWM_BIT] = 1'b1;
            end
            if (hits[6] && en[on_chip_peripheral_bus_decode_pkg::RTC_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::RTC_BIT] = 1'b1;
            end
            // The first CAN controller wins when both controllers are enabled.
            if (hits[7] && !(hits[5] && en[on_chip_peripheral_bus_decode_pkg::PWM_BIT])
                && !(hits[6] && en[on_chip_peripheral_bus_decode_pkg::RTC_BIT])) begin
                if (en[on_chip_peripheral_bus_decode_pkg::FIRST_CAN_BIT]) sel[on_chip_peripheral_bus_decode_pkg::FIRST_CAN_BIT] = 1'b1;
                else if (en[on_chip_peripheral_bus_decode_pkg::SECOND_CAN_BIT]) sel[on_chip_peripheral_bus_decode_pkg::SECOND_CAN_BIT] = 1'b1;
            end
            if (hits[8] && en[on_chip_peripheral_bus_decode_pkg::SMALL_RAM_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::SMALL_RAM_BIT] = 1'b1;
            end
            if (hits[9] && en[on_chip_peripheral_bus_decode_pkg::FLASH_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::FLASH_BIT] = 1'b1;
            end
            if (largeRamHit && en[on_chip_peripheral_bus_decode_pkg::LARGE_RAM_BIT]) begin
                sel[on_chip_peripheral_bus_decode_pkg::LARGE_RAM_BIT] = 1'b1;
            end
            hitAny = |hits || largeRamHit;
            if (sel == 12'h000) begin
                // Peripheral windows go outside only once the whole group is off.
                if (hits[0]) ext = allClear(en, PERIPH_MASK);
                if (hits[1]) ext = allClear(en, PERIPH_MASK);
                if (hits[2]) ext = allClear(en, PERIPH_MASK);
                if (hits[3]) ext = allClear(en, PERIPH_MASK);
                if (hits[4]) ext = allClear(en, PERIPH_MASK);
                if (hits[5] || hits[6] || hits[7]) ext = allClear(en, PERIPH_MASK);
                if (hits[8]) ext = 1'b1;
                if (hits[9]) ext = allClear(en, bitsOf(on_chip_peripheral_bus_decode_pkg::FLASH_BIT,
                    on_chip_peripheral_bus_decode_pkg::LARGE_RAM_BIT));
                if (largeRamHit) ext = allClear(en, bitsOf(on_chip_peripheral_bus_decode_pkg::FLASH_BIT,
                    on_chip_peripheral_bus_decode_pkg::LARGE_RAM_BIT));
            end
            state_next.select = sel;
            // A decoded window that is off but not yet released is blocked rather than sent outside.
            if (sel != 12'h000) state_next.route = on_chip_peripheral_bus_decode_pkg::ROUTE_ON_CHIP;
            else if (ext) state_next.route = on_chip_peripheral_bus_decode_pkg::ROUTE_EXTERNAL;
            else if (hitAny) state_next.route = on_chip_peripheral_bus_decode_pkg::ROUTE_NONE;
            else state_next.route = on_chip_peripheral_bus_decode_pkg::ROUTE_INTERNAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg.enables <= on_chip_peripheral_bus_decode_pkg::PERIPH_ENABLES_RESET;
            state_reg.rdata <= 16'h0000;
            state_reg.route <= on_chip_peripheral_bus_decode_pkg::ROUTE_INTERNAL;
            state_reg.select <= 12'h000;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign regHit = (regAddr == on_chip_peripheral_bus_decode_pkg::PERIPH_ENABLES_OFFSET);
    assign regRdata = state_reg.rdata;
    assign accessRoute = state_reg.route;
    assign onChipSelect = state_reg.select;
    assign peripheralEnables = state_reg.enables;
    assign firstCanPinsOwned = state_reg.enables[on_chip_peripheral_bus_decode_pkg::FIRST_CAN_BIT];
    assign secondCanPinsOwned = state_reg.enables[on_chip_peripheral_bus_decode_pkg::SECOND_CAN_BIT];

endmodule

//--- test/on_chip_peripheral_bus_decode_checker_properties.sv
// Port-level assertions for the peripheral enable decode.
`timescale 1ns/100ps
module on_chip_peripheral_bus_decode_checker (
    // Inputs of the design.
    input wire logic mclk,
    input wire logic rst,
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic globalExtBusEnable,
    input wire logic accessStart,
    input wire logic [23:0] accessAddr,
    // Outputs of the design.
    input wire logic [15:0] regRdata,
    input wire logic [1:0] accessRoute,
    input wire logic [11:0] peripheralEnables,
    input wire logic firstCanPinsOwned
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence regReq; regSel && regAddr == 16'hF024; endsequence
    sequence memReq; accessStart && accessAddr >= 24'h090000 && accessAddr <= 24'h0FFFFF; endsequence
    a_reset_default: assert property ($fell(rst) |-> peripheralEnables == 12'h005)
        else $error("enable register left reset with a wrong value");
    a_write_taken: assert property (regReq ##0 (regWrite && !globalExtBusEnable)
        |=> {4'h0, peripheralEnables} == ($past(regWdata) & 16'h0FFF)) else $error("open write not stored");
    a_write_locked: assert property (regReq ##0 (regWrite && globalExtBusEnable)
        |=> $stable(peripheralEnables)) else $error("locked write changed the enables");
    a_read_value: assert property (regReq ##0 !regWrite
        |=> regRdata == {4'h0, $past(peripheralEnables)}) else $error("read data differs from enables");
    a_reserved_zero: assert property (regRdata[15:12] == 4'h0) else $error("reserved read bits set");
    a_can_pins: assert property (firstCanPinsOwned == peripheralEnables[0])
        else $error("pin ownership wrong");
    a_mem_both_off: assert property (memReq ##0 ((peripheralEnables & 12'h028) == 12'h000)
        |=> accessRoute == 2'h2) else $error("memory window not sent outside");
    a_ram_blocked: assert property (memReq ##0 (accessAddr[19:16] == 4'hF && peripheralEnables[5]
        && !peripheralEnables[3]) |=> accessRoute == 2'h3) else $error("large memory window not blocked");
    a_route_holds: assert property (!accessStart |=> $stable(accessRoute)) else $error("route moved");
    a_small_ram_off: assert property (accessStart && accessAddr[23:11] == 13'h001C && !peripheralEnables[2]
        |=> accessRoute == 2'h2) else $error("small memory window not sent outside");
    a_periph_all_off: assert property (accessStart && accessAddr[23:11] == 13'h001D
        && (peripheralEnables & 12'hFD3) == 12'h000 |=> accessRoute == 2'h2)
        else $error("peripheral window kept");
endmodule
bind on_chip_peripheral_bus_peripheral_enable_decode on_chip_peripheral_bus_decode_checker props (.mclk(mclk), .rst(rst), .regSel(regSel),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .globalExtBusEnable(globalExtBusEnable),
    .accessStart(accessStart), .accessAddr(accessAddr), .regRdata(regRdata), .accessRoute(accessRoute),
    .peripheralEnables(peripheralEnables), .firstCanPinsOwned(firstCanPinsOwned));

//--- test/far_side_model.sv
// Far side stand-in: counts accesses handed to the external memory interface.
`timescale 1ns/100ps
module far_side_model (
    // Clock and routing.
    input wire logic mclk,
    input wire logic accessStart,
    input wire logic [1:0] accessRoute,
    // Count.
    output int extCount
);
    logic pendingReg = 1'b0;
    initial extCount = 0;
    // The route is taken one edge after the start, when the decode has settled.
    always @(posedge mclk) begin
        if (pendingReg && accessRoute == 2'h2) extCount <= extCount + 1;
        pendingReg <= accessStart;
    end
endmodule

//--- test/test_on_chip_peripheral_bus_peripheral_enable_decode.sv
// Self-checking bench for the peripheral enable decode with a reference model.
`timescale 1ns/100ps
module test_on_chip_peripheral_bus_peripheral_enable_decode;
    logic mclk = 1'b0, rst = 1'b1, regSel = 1'b0, regWrite = 1'b0, globalExtBusEnable = 1'b0, accessStart = 1'b0;
    logic [15:0] regAddr = 16'h0000, regWdata = 16'h0000, regRdata;
    logic [23:0] accessAddr = 24'h000000;
    logic regHit, firstCanPinsOwned, secondCanPinsOwned;
    logic [1:0] accessRoute;
    logic [11:0] onChipSelect, peripheralEnables, enModel = 12'h005;
    int extCount, expExt = 0, errorCnt = 0, totalChecks = 0, cycles = 0;
    logic [23:0] addrs [22] = '{24'h00E000, 24'h00E7FF, 24'h00E800, 24'h00E900, 24'h00EAFF, 24'h00EB00,
        24'h00EB7F, 24'h00EB80, 24'h00EBFF, 24'h00EC00, 24'h00ECFF, 24'h00ED00, 24'h00EDFF, 24'h00EE00,
        24'h00EFFF, 24'h090000, 24'h0EFFFF, 24'h0F0000, 24'h0FFFFF, 24'h00DFFF, 24'h00F000, 24'h100000};
    on_chip_peripheral_bus_peripheral_enable_decode dut (.mclk(mclk), .rst(rst), .regSel(regSel), .regWrite(regWrite),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
        .globalExtBusEnable(globalExtBusEnable), .accessStart(accessStart), .accessAddr(accessAddr),
        .accessRoute(accessRoute), .onChipSelect(onChipSelect), .peripheralEnables(peripheralEnables),
        .firstCanPinsOwned(firstCanPinsOwned), .secondCanPinsOwned(secondCanPinsOwned));
    far_side_model farSide (.mclk(mclk), .accessStart(accessStart), .accessRoute(accessRoute), .extCount(extCount));
    initial forever #4 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Reference decode: {route, one-hot select}; a window that is off goes outside only when released.
    function automatic logic [15:0] expRoute(input logic [23:0] a, input logic [11:0] e);
        int b;
        logic [1:0] off;
        b = -1;
        off = ((e & 12'hFD3) == 12'h000) ? 2'h2 : 2'h3;
        if (a >= 24'h00E000 && a <= 24'h00E7FF) begin
            b = 2;
            off = 2'h2;
        end else if (a >= 24'h00E800 && a <= 24'h00EBFF)
            b = a[9:8] == 2'h0 ? 8 : a[9:8] == 2'h1 ? 7 : a[9:8] == 2'h2 ? 9 : a[7] ? 11 : 10;
        else if (a >= 24'h00EC00 && a <= 24'h00EFFF)
            b = (a[9:8] == 2'h0 && e[6]) ? 6 : (a[9:8] == 2'h1 && e[4]) ? 4 : e[0] ? 0 : 1;
        else if (a >= 24'h090000 && a <= 24'h0FFFFF) begin
            b = a[19:16] == 4'hF ? 3 : 5;
            off = (e[3] | e[5]) ? 2'h3 : 2'h2;
        end
        if (b < 0) return 16'h0000;
        return e[b] ? {4'h1, 12'h001 << b} : {2'h0, off, 12'h000};
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task regOp(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        regSel <= 1'b1;
        regWrite <= wr;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regSel <= 1'b0;
        #1;
        if (wr && a == 16'hF024 && !globalExtBusEnable) enModel = d[11:0];
        if (!wr) chk(regRdata, a == 16'hF024 ? {4'h0, enModel} : 16'h0000);
        chk({4'h0, peripheralEnables}, {4'h0, enModel});
        chk({14'h0, secondCanPinsOwned, firstCanPinsOwned}, {14'h0, enModel[1:0]});
        chk({15'h0, regHit}, {15'h0, a == 16'hF024});
    endtask
    task access(input logic [23:0] a);
        logic [15:0] e;
        @(posedge mclk);
        accessStart <= 1'b1;
        accessAddr <= a;
        @(posedge mclk);
        accessStart <= 1'b0;
        #1;
        e = expRoute(a, enModel);
        if (e[13:12] == 2'h2) expExt++;
        chk({14'h0, accessRoute}, {14'h0, e[13:12]});
        chk({4'h0, onChipSelect}, {4'h0, e[11:0]});
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // The longest legal run is about 1950 cycles; anything far beyond that is a hang.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            errorCnt++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'h48DF0518));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        #1 chk({4'h0, peripheralEnables}, 16'h0005);
        regOp(1'b0, 16'hF024, 16'h0000);
        regOp(1'b0, 16'hF026, 16'h0000);
        regOp(1'b1, 16'hF026, 16'h0FFF);
        for (int i = 0; i < 40; i++) begin
            regOp(1'b1, 16'hF024, {4'h0, i < 12 ? 12'h001 << i : i == 12 ? 12'h000 : 12'($urandom)});
            foreach (addrs[j]) access(addrs[j]);
            access(24'h00E000 + 24'($urandom % 4096));
        end
        // The far side counts one edge after the route settles, so let the last access land first.
        @(posedge mclk);
        #1 chk(16'(extCount), 16'(expExt));
        @(posedge mclk);
        globalExtBusEnable <= 1'b1;
        regOp(1'b1, 16'hF024, 16'h0ABC);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        enModel = 12'h005;
        #1 chk({4'h0, peripheralEnables}, 16'h0005);
        conclude();
    end
endmodule
